// *** wuti_pkg.sv ***
// constants shared by the wake, usb-limit and thermal interrupt block
package wuti_pkg;
    // ======================================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] IDX_STATUS_TWO = 10'h01a;
    localparam logic [9:0] IDX_WAKE_STATUS = 10'h01f;
    localparam logic [9:0] IDX_MASK_TWO = 10'h022;
    localparam logic [9:0] IDX_WAKE_MASK = 10'h027;
    localparam logic [9:0] IDX_EVENT_STATUS = 10'h040;
    localparam logic [9:0] IDX_EVENT_MASK = 10'h041;
    localparam logic [9:0] IDX_HOLD_TIME = 10'h042;

    // ======================================================================
    // field positions
    localparam int BIT_CURRENT_LIMIT = 10;
    localparam int BIT_THERMAL_WARNING = 2;
    localparam int BIT_THERMAL_SHUTDOWN = 1;
    localparam int BIT_FROM_OFF = 6;
    localparam int BIT_FROM_SLEEP = 5;
    localparam int BIT_CONVERTER_FAULT = 4;
    localparam int BIT_HEARTBEAT_MISS = 3;
    localparam int BIT_POWER_PIN_HOLD = 2;
    localparam int BIT_KEY_HOLD = 1;
    localparam int BIT_WAKE_PIN_HOLD = 0;
    localparam int BIT_EVT_USB = 0;
    localparam int BIT_EVT_WAKE = 1;
    localparam int BIT_EVT_SYSTEM = 2;

    // ======================================================================
    // writable field masks and reset values
    localparam logic [15:0] MASK_TWO_BITS = 16'h0406;
    localparam logic [15:0] WAKE_BITS = 16'h007f;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [2:0] EVENT_MASK_RESET = 3'h0;
    localparam logic [7:0] HOLD_TIME_RESET = 8'h0a;

    // ======================================================================
    // timing: hold time is counted in milliseconds
    localparam int CLOCK_HZ = 50000000;
    localparam int HOLD_UNIT_US = 1000;
    localparam int HOLD_UNIT_CYCLES = CLOCK_HZ / 1000000 * HOLD_UNIT_US;

    // ======================================================================
    // synchronised input positions
    localparam int IN_USB_LIMIT = 0;
    localparam int IN_FROM_OFF = 1;
    localparam int IN_FROM_SLEEP = 2;
    localparam int IN_CONV_FAULT = 3;
    localparam int IN_HEARTBEAT = 4;
    localparam int IN_POWER_PIN = 5;
    localparam int IN_KEY = 6;
    localparam int IN_WAKE_PIN = 7;
    localparam int IN_TEMP_WARN = 8;
    localparam int IN_TEMP_SHUT = 9;
    localparam int IN_TEMP_COOL = 10;
    localparam int IN_COUNT = 11;
endpackage

// *** wuti_hold_detect.sv ***
// hold detector: reports a pin held longer than the programmed time
module wuti_hold_detect
    import wuti_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // timebase and limit
    input wire logic tick,
    input wire logic [7:0] limit,
    // pin and result
    input wire logic pin,
    output logic held
);
    logic [8:0] count;

    // count whole time units while asserted; saturate so a long press stays held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 9'h000;
        end else if (!pin) begin
            count <= 9'h000;
        end else if (tick && count != 9'h1ff) begin
            count <= count + 9'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held <= 1'b0;
        end else begin
            held <= pin && (count > {1'b0, limit});
        end
    end
endmodule

// *** wuti_irq_top.sv ***
// second-level usb-limit, wake-cause and thermal interrupt block on ahb-lite
module wuti_irq_top
    import wuti_pkg::*;
#(
    parameter int HOLD_UNIT_CYCLES_P = HOLD_UNIT_CYCLES
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // event sources, asynchronous levels
    input wire logic usb_limit_in,
    input wire logic from_off_in,
    input wire logic from_sleep_in,
    input wire logic converter_fault_in,
    input wire logic heartbeat_miss_in,
    input wire logic power_request_pin,
    input wire logic key_pin,
    input wire logic wake_pin,
    input wire logic temp_warning_in,
    input wire logic temp_shutdown_in,
    input wire logic temp_cool_in,
    // first-level interrupts and control
    output logic usb_irq,
    output logic wake_cause_irq,
    output logic system_irq,
    output logic irq,
    output logic thermal_shutdown
);
    // ======================================================================
    // decode
    typedef enum logic [2:0] {
        WUTI_REG_NONE, WUTI_REG_STATUS_TWO, WUTI_REG_WAKE_STATUS, WUTI_REG_MASK_TWO,
        WUTI_REG_WAKE_MASK, WUTI_REG_EVENT_STATUS, WUTI_REG_EVENT_MASK, WUTI_REG_HOLD_TIME
    } wuti_reg_e;

    function automatic wuti_reg_e wuti_decode(input logic [31:0] addr);
        wuti_reg_e r;
        r = WUTI_REG_NONE;
        if (addr[31:12] == 20'h00000 && addr[1:0] == 2'b00) begin
            case (addr[11:2])
                IDX_STATUS_TWO: r = WUTI_REG_STATUS_TWO;
                IDX_WAKE_STATUS: r = WUTI_REG_WAKE_STATUS;
                IDX_MASK_TWO: r = WUTI_REG_MASK_TWO;
                IDX_WAKE_MASK: r = WUTI_REG_WAKE_MASK;
                IDX_EVENT_STATUS: r = WUTI_REG_EVENT_STATUS;
                IDX_EVENT_MASK: r = WUTI_REG_EVENT_MASK;
                IDX_HOLD_TIME: r = WUTI_REG_HOLD_TIME;
                default: r = WUTI_REG_NONE;
            endcase
        end
        return r;
    endfunction

    // ======================================================================
    // registers
    logic [15:0] status_two;
    logic [15:0] wake_status;
    logic [15:0] mask_two;
    logic [15:0] wake_mask;
    logic [2:0] event_status;
    logic [2:0] event_mask;
    logic [7:0] hold_time;

    // ======================================================================
    // input synchronisers: stage one is read only by stage two
    logic [IN_COUNT-1:0] sync_a;
    logic [IN_COUNT-1:0] sync_b;
    logic [IN_COUNT-1:0] raw_in;
    assign raw_in = {temp_cool_in, temp_shutdown_in, temp_warning_in, wake_pin, key_pin,
                     power_request_pin, heartbeat_miss_in, converter_fault_in, from_sleep_in,
                     from_off_in, usb_limit_in};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    // ======================================================================
    // hold timers on a millisecond enable
    logic [31:0] div_count;
    logic tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_count <= 32'h00000000;
            tick <= 1'b0;
        end else if (div_count >= 32'(HOLD_UNIT_CYCLES_P - 1)) begin
            div_count <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            div_count <= div_count + 32'h00000001;
            tick <= 1'b0;
        end
    end

    logic [2:0] hold_pin;
    logic [2:0] hold_seen;
    assign hold_pin = {sync_b[IN_POWER_PIN], sync_b[IN_KEY], sync_b[IN_WAKE_PIN]};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_hold
            wuti_hold_detect u_hold (
                .hclk(hclk),
                .hresetn(hresetn),
                .tick(tick),
                .limit(hold_time),
                .pin(hold_pin[g]),
                .held(hold_seen[g])
            );
        end
    endgenerate

    // ======================================================================
    // source levels and rising-edge detection
    // previous levels reset low, so a cause still asserted as reset releases
    // is caught as an edge and recorded once
    logic [15:0] level_two;
    logic [15:0] level_wake;
    logic [15:0] prev_two;
    logic [15:0] prev_wake;
    logic [15:0] rise_two;
    logic [15:0] rise_wake;

    always_comb begin
        level_two = 16'h0000;
        level_two[BIT_CURRENT_LIMIT] = sync_b[IN_USB_LIMIT];
        level_two[BIT_THERMAL_WARNING] = sync_b[IN_TEMP_WARN];
        level_two[BIT_THERMAL_SHUTDOWN] = sync_b[IN_TEMP_SHUT];
        level_wake = 16'h0000;
        level_wake[BIT_FROM_OFF] = sync_b[IN_FROM_OFF];
        level_wake[BIT_FROM_SLEEP] = sync_b[IN_FROM_SLEEP];
        level_wake[BIT_CONVERTER_FAULT] = sync_b[IN_CONV_FAULT];
        level_wake[BIT_HEARTBEAT_MISS] = sync_b[IN_HEARTBEAT];
        level_wake[BIT_POWER_PIN_HOLD] = hold_seen[2];
        level_wake[BIT_KEY_HOLD] = hold_seen[1];
        level_wake[BIT_WAKE_PIN_HOLD] = hold_seen[0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_two <= 16'h0000;
            prev_wake <= 16'h0000;
        end else begin
            prev_two <= level_two;
            prev_wake <= level_wake;
        end
    end

    assign rise_two = level_two & ~prev_two;
    assign rise_wake = level_wake & ~prev_wake;

    // ======================================================================
    // ahb-lite: zero wait states, read data captured at the address phase
    logic access;
    wuti_reg_e acc_reg;
    logic wr_pending;
    wuti_reg_e wr_reg;
    logic rd_two;
    logic rd_wake;
    logic [31:0] next_rdata;

    assign access = hsel && hready && htrans[1];
    assign acc_reg = wuti_decode(haddr);
    assign rd_two = access && !hwrite && acc_reg == WUTI_REG_STATUS_TWO;
    assign rd_wake = access && !hwrite && acc_reg == WUTI_REG_WAKE_STATUS;

    always_comb begin
        next_rdata = 32'h00000000;
        case (acc_reg)
            WUTI_REG_STATUS_TWO: next_rdata = {16'h0000, status_two};
            WUTI_REG_WAKE_STATUS: next_rdata = {16'h0000, wake_status};
            WUTI_REG_MASK_TWO: next_rdata = {16'h0000, mask_two};
            WUTI_REG_WAKE_MASK: next_rdata = {16'h0000, wake_mask};
            WUTI_REG_EVENT_STATUS: next_rdata = {29'h0, event_status};
            WUTI_REG_EVENT_MASK: next_rdata = {29'h0, event_mask};
            WUTI_REG_HOLD_TIME: next_rdata = {24'h000000, hold_time};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (access && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ready is held low in reset so a master cannot start a transfer
    // while reset still holds the flags and masks at their reset values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_reg <= WUTI_REG_NONE;
        end else if (hready) begin
            wr_pending <= access && hwrite;
            wr_reg <= acc_reg;
        end
    end

    // ======================================================================
    // status flags: a new edge wins over the clear of a read in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_two <= 16'h0000;
        end else begin
            status_two <= ((status_two & ~(rd_two ? status_two : 16'h0000))
                          | rise_two) & MASK_TWO_BITS;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_status <= 16'h0000;
        end else begin
            wake_status <= ((wake_status & ~(rd_wake ? wake_status : 16'h0000))
                           | rise_wake) & WAKE_BITS;
        end
    end

    // ======================================================================
    // writable registers
    // unused mask positions are cut off on write and read back as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_two <= MASK_RESET;
            wake_mask <= MASK_RESET;
            event_mask <= EVENT_MASK_RESET;
            hold_time <= HOLD_TIME_RESET;
        end else if (wr_pending) begin
            case (wr_reg)
                WUTI_REG_MASK_TWO: mask_two <= hwdata[15:0] & MASK_TWO_BITS;
                WUTI_REG_WAKE_MASK: wake_mask <= hwdata[15:0] & WAKE_BITS;
                WUTI_REG_EVENT_MASK: event_mask <= hwdata[2:0];
                WUTI_REG_HOLD_TIME: hold_time <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // first-level interrupts: a mask bit of one blocks its flag
    logic next_usb_irq;
    logic next_wake_irq;
    logic next_system_irq;
    logic [2:0] first_level;
    logic [2:0] prev_first;
    logic [2:0] evt_rise;
    logic [2:0] evt_clear;

    assign next_usb_irq = status_two[BIT_CURRENT_LIMIT] & ~mask_two[BIT_CURRENT_LIMIT];
    assign next_wake_irq = |(wake_status[6:0] & ~wake_mask[6:0]);
    assign next_system_irq = |(status_two[2:1] & ~mask_two[2:1]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            usb_irq <= 1'b0;
            wake_cause_irq <= 1'b0;
            system_irq <= 1'b0;
        end else begin
            usb_irq <= next_usb_irq;
            wake_cause_irq <= next_wake_irq;
            system_irq <= next_system_irq;
        end
    end

    // event register records each new first-level assertion; write one to clear
    assign first_level = {system_irq, wake_cause_irq, usb_irq};
    assign evt_rise = first_level & ~prev_first;
    assign evt_clear = (wr_pending && wr_reg == WUTI_REG_EVENT_STATUS) ? hwdata[2:0] : 3'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_first <= 3'h0;
            event_status <= 3'h0;
            irq <= 1'b0;
        end else begin
            prev_first <= first_level;
            event_status <= (event_status & ~evt_clear) | evt_rise;
            irq <= |(event_status & ~event_mask);
        end
    end

    // ======================================================================
    // thermal shutdown: latched on the edge, released only when cool
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thermal_shutdown <= 1'b0;
        end else if (rise_two[BIT_THERMAL_SHUTDOWN]) begin
            thermal_shutdown <= 1'b1;
        end else if (sync_b[IN_TEMP_COOL] && !sync_b[IN_TEMP_SHUT]) begin
            thermal_shutdown <= 1'b0;
        end
    end
endmodule

// *** wuti_irq_chk.sv ***
// assertion checker for the wake, usb-limit and thermal interrupt block
module wuti_irq_chk
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // sources
    input wire logic from_off_in,
    input wire logic temp_shutdown_in,
    input wire logic temp_cool_in,
    // first-level outputs
    input wire logic usb_irq,
    input wire logic wake_cause_irq,
    input wire logic system_irq,
    input wire logic irq,
    input wire logic thermal_shutdown
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ======================================================================
    // thermal restart steps
    sequence cool_low_s;
        (!temp_cool_in) [*4];
    endsequence
    sequence cool_long_s;
        (temp_cool_in && !temp_shutdown_in) [*8];
    endsequence

    // ======================================================================
    // properties
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("slave response not okay");
    ready_high_a: assert property ($past(hresetn) |-> hreadyout)
        else $error("hreadyout low after reset");
    reset_quiet_a: assert property (
        $rose(hresetn) |-> (!irq && !usb_irq && !wake_cause_irq && !system_irq
        && !thermal_shutdown && !hreadyout) ##1 hreadyout)
        else $error("outputs not quiet at reset release");
    wake_boot_a: assert property (
        $rose(hresetn) && from_off_in |-> ##[2:6] wake_cause_irq)
        else $error("boot cause not reported");
    shut_set_a: assert property ($rose(temp_shutdown_in) |-> ##[2:5] thermal_shutdown)
        else $error("no shutdown after over-temperature edge");
    shut_hold_a: assert property (cool_low_s ##0 thermal_shutdown |=> thermal_shutdown)
        else $error("shutdown left while still hot");
    shut_free_a: assert property (cool_long_s |-> !thermal_shutdown)
        else $error("shutdown kept after cooling");
    irq_follow_a: assert property (
        $rose(usb_irq) || $rose(wake_cause_irq) || $rose(system_irq) |-> ##[1:3] irq)
        else $error("top interrupt missed a first-level rise");
endmodule

bind wuti_irq_top wuti_irq_chk i_wuti_irq_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .from_off_in(from_off_in),
    .temp_shutdown_in(temp_shutdown_in),
    .temp_cool_in(temp_cool_in),
    .usb_irq(usb_irq),
    .wake_cause_irq(wake_cause_irq),
    .system_irq(system_irq),
    .irq(irq),
    .thermal_shutdown(thermal_shutdown)
);

// *** tb_top.sv ***
// self-checking bench for the wake, usb-limit and thermal interrupt block
module tb_top
    import wuti_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short hold unit keeps the hold tests brief
    localparam int UNIT = 4;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [6:0] wk, m, e;
    logic usb_in, tw_in, ts_in, cool_in;
    logic usb_irq, wake_cause_irq, system_irq, irq, thermal_shutdown;
    int bad_count = 0;
    int samples_checked = 0;
    integer seed = 80;

    assign hready = hreadyout;
    always #10 hclk = ~hclk;

    wuti_irq_top #(.HOLD_UNIT_CYCLES_P(UNIT)) i_wuti_irq_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .usb_limit_in(usb_in), .from_off_in(wk[6]),
        .from_sleep_in(wk[5]), .converter_fault_in(wk[4]), .heartbeat_miss_in(wk[3]),
        .power_request_pin(wk[2]), .key_pin(wk[1]), .wake_pin(wk[0]),
        .temp_warning_in(tw_in), .temp_shutdown_in(ts_in), .temp_cool_in(cool_in),
        .usb_irq(usb_irq), .wake_cause_irq(wake_cause_irq), .system_irq(system_irq),
        .irq(irq), .thermal_shutdown(thermal_shutdown)
    );

    // ======================================================================
    // bus and compare tasks
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, idx, 32'h0, d);
        cmp_word(d, exp);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, idx, d, unused);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic done_test(input string name);
        $display("test %s finished, %0d mismatches so far", name, bad_count);
    endtask
    function automatic logic exp_irq(input logic [6:0] f, input logic [6:0] msk);
        return |(f & ~msk);
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ======================================================================
    // watchdog: tests need under 3000 cycles
    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end

    // ======================================================================
    // main sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {usb_in, tw_in, ts_in, cool_in} = 4'h0;
        // start from off: cause must be seen at release
        wk = 7'h40;
        settle(6);
        hresetn <= 1'b1;
        settle(8);
        rd_chk(IDX_MASK_TWO, 32'h0);
        rd_chk(IDX_WAKE_MASK, 32'h0);
        rd_chk(IDX_HOLD_TIME, 32'h0a);
        rd_chk(10'h3ff, 32'h0);
        cmp_bit(wake_cause_irq, 1'b1);
        rd_chk(IDX_WAKE_STATUS, 32'h40);
        rd_chk(IDX_WAKE_STATUS, 32'h0);
        cmp_bit(wake_cause_irq, 1'b0);
        wk <= 7'h0;
        wr(IDX_MASK_TWO, 32'hffffffff);
        rd_chk(IDX_MASK_TWO, 32'h406);
        wr(IDX_WAKE_MASK, 32'hffffffff);
        rd_chk(IDX_WAKE_MASK, 32'h7f);
        done_test("reset");
        for (int i = 3; i < 7; i++) begin
            wk[i] <= 1'b1;
            settle(6);
            rd_chk(IDX_WAKE_STATUS, 32'h1 << i);
            settle(4);
            rd_chk(IDX_WAKE_STATUS, 32'h0);
            wk[i] <= 1'b0;
            settle(1);
        end
        done_test("causes");
        for (int k = 0; k < 8; k++) begin
            m = 7'($random(seed));
            e = 7'($random(seed));
            if (k < 2) begin
                m = k ? 7'h0 : 7'h7f;
                e = 7'h78;
            end
            e[2:0] = 3'h0;
            wr(IDX_WAKE_MASK, {25'h0, m});
            wk <= e;
            settle(7);
            cmp_bit(wake_cause_irq, exp_irq(e, m));
            rd_chk(IDX_WAKE_STATUS, {25'h0, e});
            wk <= 7'h0;
            settle(3);
            cmp_bit(wake_cause_irq, 1'b0);
        end
        done_test("wake mask");
        wr(IDX_WAKE_MASK, 32'h0);
        wr(IDX_HOLD_TIME, 32'h2);
        for (int i = 0; i < 3; i++) begin
            // a press of two units at most must not count
            wk[i] <= 1'b1;
            settle(6);
            wk[i] <= 1'b0;
            settle(20);
            rd_chk(IDX_WAKE_STATUS, 32'h0);
            wk[i] <= 1'b1;
            settle(40);
            rd_chk(IDX_WAKE_STATUS, 32'h1 << i);
            wk[i] <= 1'b0;
            settle(1);
        end
        done_test("hold");
        wr(IDX_MASK_TWO, 32'h400);
        usb_in <= 1'b1;
        settle(6);
        cmp_bit(usb_irq, 1'b0);
        wr(IDX_MASK_TWO, 32'h0);
        settle(2);
        cmp_bit(usb_irq, 1'b1);
        rd_chk(IDX_STATUS_TWO, 32'h400);
        settle(6);
        rd_chk(IDX_STATUS_TWO, 32'h0);
        settle(2);
        cmp_bit(usb_irq, 1'b0);
        usb_in <= 1'b0;
        rd_chk(IDX_EVENT_STATUS, 32'h3);
        cmp_bit(irq, 1'b1);
        wr(IDX_EVENT_MASK, 32'h7);
        settle(2);
        cmp_bit(irq, 1'b0);
        rd_chk(IDX_EVENT_MASK, 32'h7);
        wr(IDX_EVENT_MASK, 32'h0);
        wr(IDX_EVENT_STATUS, 32'h3);
        settle(2);
        rd_chk(IDX_EVENT_STATUS, 32'h0);
        cmp_bit(irq, 1'b0);
        done_test("usb");
        wr(IDX_MASK_TWO, 32'h6);
        tw_in <= 1'b1;
        settle(6);
        cmp_bit(system_irq, 1'b0);
        rd_chk(IDX_STATUS_TWO, 32'h4);
        ts_in <= 1'b1;
        settle(6);
        cmp_bit(thermal_shutdown, 1'b1);
        wr(IDX_MASK_TWO, 32'h0);
        settle(2);
        cmp_bit(system_irq, 1'b1);
        rd_chk(IDX_STATUS_TWO, 32'h2);
        ts_in <= 1'b0;
        settle(10);
        cmp_bit(thermal_shutdown, 1'b1);
        cool_in <= 1'b1;
        settle(6);
        cmp_bit(thermal_shutdown, 1'b0);
        tw_in <= 1'b0;
        // let the cooled state last long enough for the release check
        settle(10);
        done_test("thermal");
        print_verdict();
    end
endmodule
